// ==== src/fcr_top.sv ====
// Notes on behaviour
// - Three fuse bytes; programmed bit reads zero, unprogrammed reads one.
// - Extended bits 5,4,3 select force, A level, B level; defaults one.
// - Extended bits 2..0 form brown-out level field, default ones.
// - Force fuse unprogrammed: PWM pins behave as ordinary port pins.
// - Force fuse programmed: reset forces PWM pins to fuse-chosen level.
// - Forced level holds after reset until first config register write.
// - A outputs high when A level fuse programmed, else low.
// - B outputs high when B level fuse programmed, else low.
// - High byte layout; all default unprogrammed except serial enable and the two boot size bits.
// - Serial enable fuse unreadable and unwritable in serial mode.
// - Boot size fuses default programmed, largest boot section.
// - Low byte layout, default clock source pattern 0010.
// - Start-up time fuses default to pattern 10.
// - Clock output fuse programmed drives system clock on port B bit 0; here a copy toggling each cycle, at half the clock rate.
// - Chip erase leaves all fuse bits unchanged.
// - Lock bit one programmed refuses any fuse change.
// - Fuses latched on programming entry; changes apply after exit.
// - Preserve fuse acts at once; fuses latched at power-up normally; here the copy follows the store every cycle outside programming mode.
//
// Top of the fuse configuration block.
// Assumes the programming port is synchronous to CORE_CLK.
`timescale 1ns/1ps
module fcr_top #(
   parameter int N_PWM = 3
) (
   // Clock and reset
   input  wire logic                   CORE_CLK,
   input  wire logic                   RST,
   // Programming interface
   input  wire logic                   PROG_MODE,
   input  wire logic                   SERIAL_MODE,
   input  wire logic                   MEMORY_LOCK_BIT_ONE_N,
   input  wire fcr_pkg::fcr_prog_req_t PROG_REQ,
   output logic [7:0]                  PROG_RDATA,
   // Software side
   input  wire logic                   PWM_OUTPUT_CONFIG_REG_WR,
   // PWM unit
   input  wire logic [N_PWM-1:0]       PWM_A_IN,
   input  wire logic [N_PWM-1:0]       PWM_B_IN,
   output logic [N_PWM-1:0]            PWM_A_SIDE_OUTPUTS,
   output logic [N_PWM-1:0]            PWM_B_SIDE_OUTPUTS,
   output logic                        PWM_FORCING,
   // Port B bit zero
   input  wire logic                   PORT_B_BIT_ZERO_IN,
   output logic                        PORT_B_BIT_ZERO,
   // Applied configuration
   output fcr_pkg::fcr_cfg_t           CFG,
   output logic [23:0]                 LATCHED_FUSES
);

   logic [7:0]        ext_s;
   logic [7:0]        hi_s;
   logic [7:0]        lo_s;
   logic [7:0]        ext_q = fcr_pkg::EXT_DEFAULT;
   logic [7:0]        hi_q  = fcr_pkg::HI_DEFAULT;
   logic [7:0]        lo_q  = fcr_pkg::LO_DEFAULT;
   logic              clkdiv_q;
   logic              hold_d;
   logic              ee_preserve_live;
   fcr_pkg::fcr_cfg_t cfg_d;
   logic              pb0_d;

   fcr_fuse_store #(
      .W (fcr_pkg::FUSE_W)
   ) u_store (
      .clk            (CORE_CLK),
      .rst            (RST),
      .req            (PROG_REQ),
      .serial_mode    (SERIAL_MODE),
      .lock_bit_one_n (MEMORY_LOCK_BIT_ONE_N),
      .ext_q          (ext_s),
      .hi_q           (hi_s),
      .lo_q           (lo_s),
      .rdata_q        (PROG_RDATA)
   );

   // hold latched copy in programming mode.
   assign hold_d = PROG_MODE;

   assign ee_preserve_live = hi_s[fcr_pkg::HI_EE_PRESERVE_BIT];

   assign cfg_d.ext_reset_disable        = hi_q[fcr_pkg::HI_EXT_RST_DIS_BIT];
   assign cfg_d.onchip_debug_enable      = hi_q[fcr_pkg::HI_DEBUG_EN_BIT];
   assign cfg_d.serial_prog_enable       = hi_q[fcr_pkg::HI_SERIAL_PROG_BIT];
   assign cfg_d.watchdog_always_on       = hi_q[fcr_pkg::HI_WDT_ON_BIT];
   assign cfg_d.eeprom_preserve_on_erase = ee_preserve_live;
   assign cfg_d.boot_size_sel            = hi_q[fcr_pkg::HI_BOOT_MSB:fcr_pkg::HI_BOOT_LSB];
   assign cfg_d.reset_vector_select      = hi_q[fcr_pkg::HI_RST_VEC_BIT];
   assign cfg_d.clock_divide_by_eight    = lo_q[fcr_pkg::LO_CLOCK_DIVIDE_BY_EIGHT_BIT];
   assign cfg_d.clock_output_enable      = lo_q[fcr_pkg::LO_CLOCK_OUTPUT_ENABLE_BIT];
   assign cfg_d.startup_time_sel         = lo_q[fcr_pkg::LO_SUT_MSB:fcr_pkg::LO_SUT_LSB];
   assign cfg_d.clock_source_sel         = lo_q[fcr_pkg::LO_CKSEL_MSB:fcr_pkg::LO_CKSEL_LSB];
   assign cfg_d.brownout_level           = ext_q[fcr_pkg::EXT_BOD_MSB:fcr_pkg::EXT_BOD_LSB];

   // programmed clock-out fuse. A toggling copy of the clock stands in for it
   // since an output straight from a flip-flop cannot carry the clock itself.
   assign pb0_d = ~lo_q[fcr_pkg::LO_CLOCK_OUTPUT_ENABLE_BIT] ? ~clkdiv_q : PORT_B_BIT_ZERO_IN;

   // copy runs through reset.
   // Reset must not clear it, or a programmed force fuse could never take effect.
   always_ff @(posedge CORE_CLK) begin
      if (!hold_d) begin
         ext_q <= ext_s;
         hi_q  <= hi_s;
         lo_q  <= lo_s;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         clkdiv_q <= 1'b0;
      end else begin
         clkdiv_q <= pb0_d;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         CFG             <= '0;
         LATCHED_FUSES   <= '0;
         PORT_B_BIT_ZERO <= 1'b0;
      end else begin
         CFG             <= cfg_d;
         LATCHED_FUSES   <= {ext_q, hi_q, lo_q};
         PORT_B_BIT_ZERO <= pb0_d;
      end
   end

   fcr_pwm_force #(
      .N (N_PWM)
   ) u_force (
      .clk        (CORE_CLK),
      .rst        (RST),
      .force_en_n (ext_q[fcr_pkg::EXT_FORCE_EN_BIT]),
      .a_level_n  (ext_q[fcr_pkg::EXT_A_LEVEL_BIT]),
      .b_level_n  (ext_q[fcr_pkg::EXT_B_LEVEL_BIT]),
      .cfg_write  (PWM_OUTPUT_CONFIG_REG_WR),
      .pwm_a_in   (PWM_A_IN),
      .pwm_b_in   (PWM_B_IN),
      .pwm_a_q    (PWM_A_SIDE_OUTPUTS),
      .pwm_b_q    (PWM_B_SIDE_OUTPUTS),
      .forcing_q  (PWM_FORCING)
   );

endmodule : fcr_top

// ==== src/fcr_pkg.sv ====
// Package for the fuse configuration block: fuse byte layouts, defaults and commands.
// Assumes nothing beyond a SystemVerilog compiler.
package fcr_pkg;

   localparam int FUSE_W = 8;

   // Extended byte field positions.
   localparam int EXT_FORCE_EN_BIT = 5;
   localparam int EXT_A_LEVEL_BIT  = 4;
   localparam int EXT_B_LEVEL_BIT  = 3;
   localparam int EXT_BOD_MSB      = 2;
   localparam int EXT_BOD_LSB      = 0;

   // High byte field positions.
   localparam int HI_EXT_RST_DIS_BIT = 7;
   localparam int HI_DEBUG_EN_BIT    = 6;
   localparam int HI_SERIAL_PROG_BIT = 5;
   localparam int HI_WDT_ON_BIT      = 4;
   localparam int HI_EE_PRESERVE_BIT = 3;
   localparam int HI_BOOT_MSB        = 2;
   localparam int HI_BOOT_LSB        = 1;
   localparam int HI_RST_VEC_BIT     = 0;

   // Low byte field positions.
   localparam int LO_CLOCK_DIVIDE_BY_EIGHT_BIT = 7;
   localparam int LO_CLOCK_OUTPUT_ENABLE_BIT  = 6;
   localparam int LO_SUT_MSB    = 5;
   localparam int LO_SUT_LSB    = 4;
   localparam int LO_CKSEL_MSB  = 3;
   localparam int LO_CKSEL_LSB  = 0;

   // Default (erased-state) contents; a zero bit means programmed.
   localparam logic [7:0] EXT_DEFAULT = 8'hFF;
   localparam logic [7:0] HI_DEFAULT  = 8'hD9;
   localparam logic [7:0] LO_DEFAULT  = 8'h62;

   // Fuse byte selector used by the programming port.
   typedef enum logic [1:0] {
      FCR_SEL_LOW  = 2'b00,
      FCR_SEL_HIGH = 2'b01,
      FCR_SEL_EXT  = 2'b10
   } fcr_sel_t;

   // Programming port request.
   typedef struct packed {
      logic       wr;
      logic       rd;
      fcr_sel_t   sel;
      logic [7:0] data;
   } fcr_prog_req_t;

   // Decoded, applied fuse values for the rest of the chip.
   typedef struct packed {
      logic       ext_reset_disable;
      logic       onchip_debug_enable;
      logic       serial_prog_enable;
      logic       watchdog_always_on;
      logic       eeprom_preserve_on_erase;
      logic [1:0] boot_size_sel;
      logic       reset_vector_select;
      logic       clock_divide_by_eight;
      logic       clock_output_enable;
      logic [1:0] startup_time_sel;
      logic [3:0] clock_source_sel;
      logic [2:0] brownout_level;
   } fcr_cfg_t;

endpackage : fcr_pkg

// ==== src/fcr_fuse_store.sv ====
// Non-volatile fuse byte store with lock and serial-mode guards.
// Assumes the programming port presents one-cycle write and read strobes.
`timescale 1ns/1ps
module fcr_fuse_store #(
   parameter int W = fcr_pkg::FUSE_W
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Programming port
   input  wire fcr_pkg::fcr_prog_req_t req,
   input  wire logic                  serial_mode,
   input  wire logic                  lock_bit_one_n,
   // Stored contents
   output logic [W-1:0]               ext_q,
   output logic [W-1:0]               hi_q,
   output logic [W-1:0]               lo_q,
   output logic [W-1:0]               rdata_q
);

   logic [W-1:0] hi_wdata;
   logic [W-1:0] hi_rdata;
   logic         wr_ok;
   logic [W-1:0] sel_data;
   // The cells are non-volatile, so device reset leaves them alone.
   // The initial value stands for the erased state seen at power-up.
   logic [W-1:0] ext_mem_q = W'(fcr_pkg::EXT_DEFAULT);
   logic [W-1:0] hi_mem_q  = W'(fcr_pkg::HI_DEFAULT);
   logic [W-1:0] lo_mem_q  = W'(fcr_pkg::LO_DEFAULT);

   assign ext_q = ext_mem_q;
   assign hi_q  = hi_mem_q;
   assign lo_q  = lo_mem_q;

   assign wr_ok = req.wr & lock_bit_one_n;

   assign hi_wdata = serial_mode ?
      {req.data[W-1:fcr_pkg::HI_SERIAL_PROG_BIT+1], hi_q[fcr_pkg::HI_SERIAL_PROG_BIT],
       req.data[fcr_pkg::HI_SERIAL_PROG_BIT-1:0]} : req.data;
   assign hi_rdata = serial_mode ?
      (hi_q | (W'(1) << fcr_pkg::HI_SERIAL_PROG_BIT)) : hi_q;

   assign sel_data = (req.sel == fcr_pkg::FCR_SEL_EXT)  ? ext_q :
                     (req.sel == fcr_pkg::FCR_SEL_HIGH) ? hi_rdata : lo_q;

   // no erase input exists, so erase leaves fuses alone.
   always_ff @(posedge clk) begin
      if (wr_ok && req.sel == fcr_pkg::FCR_SEL_EXT) begin
         ext_mem_q <= req.data;
      end
      if (wr_ok && req.sel == fcr_pkg::FCR_SEL_HIGH) begin
         hi_mem_q <= hi_wdata;
      end
      if (wr_ok && req.sel == fcr_pkg::FCR_SEL_LOW) begin
         lo_mem_q <= req.data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (req.rd) begin
         rdata_q <= sel_data;
      end
   end

endmodule : fcr_fuse_store

// ==== src/fcr_pwm_force.sv ====
// Reset-time forcing of the power-stage PWM outputs.
// Assumes fuse inputs are already latched and stable during reset.
`timescale 1ns/1ps
module fcr_pwm_force #(
   parameter int N = 3
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Latched fuses
   input  wire logic         force_en_n,
   input  wire logic         a_level_n,
   input  wire logic         b_level_n,
   // Software write strobe
   input  wire logic         cfg_write,
   // PWM side
   input  wire logic [N-1:0] pwm_a_in,
   input  wire logic [N-1:0] pwm_b_in,
   output logic [N-1:0]      pwm_a_q,
   output logic [N-1:0]      pwm_b_q,
   output logic              forcing_q
);

   logic         force_d;
   logic [N-1:0] a_d;
   logic [N-1:0] b_d;

   assign force_d = rst ? ~force_en_n : (forcing_q & ~cfg_write);

   assign a_d = force_d ? {N{~a_level_n}} : pwm_a_in;
   assign b_d = force_d ? {N{~b_level_n}} : pwm_b_in;

   // Clocked through reset so the forced level shows while reset is held.
   always_ff @(posedge clk) begin
      forcing_q <= force_d;
      pwm_a_q   <= a_d;
      pwm_b_q   <= b_d;
   end

endmodule : fcr_pwm_force

// ==== sim/fcr_checker.sv ====
// Port-level checker for the fuse configuration block top.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module fcr_checker #(
   parameter int N_PWM = 3
) (
   // Clock and reset
   input wire logic                   CORE_CLK,
   input wire logic                   RST,
   // Programming interface
   input wire logic                   PROG_MODE,
   input wire logic                   SERIAL_MODE,
   input wire fcr_pkg::fcr_prog_req_t PROG_REQ,
   input wire logic [7:0]             PROG_RDATA,
   // PWM and port pins
   input wire logic                   PWM_OUTPUT_CONFIG_REG_WR,
   input wire logic [N_PWM-1:0]       PWM_A_IN,
   input wire logic [N_PWM-1:0]       PWM_B_IN,
   input wire logic [N_PWM-1:0]       PWM_A_SIDE_OUTPUTS,
   input wire logic [N_PWM-1:0]       PWM_B_SIDE_OUTPUTS,
   input wire logic                   PWM_FORCING,
   input wire logic                   PORT_B_BIT_ZERO_IN,
   input wire logic                   PORT_B_BIT_ZERO,
   // Applied configuration
   input wire fcr_pkg::fcr_cfg_t      CFG,
   input wire logic [23:0]            LATCHED_FUSES
);
   logic [2:0] age_q;
   logic [2:0] age_d;
   logic       quiet;
   // Applied copies lag a write by two cycles, so checks wait until four have passed.
   assign age_d = (PROG_REQ.wr || PROG_MODE) ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
   assign quiet = (age_q >= 3'h4);
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST)
         age_q <= 3'h0;
      else
         age_q <= age_d;
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   property p_ext_read;
      PROG_REQ.rd && PROG_REQ.sel == fcr_pkg::FCR_SEL_EXT && quiet |-> ##2 PROG_RDATA == LATCHED_FUSES[23:16];
   endproperty
   a_ext_read: assert property (p_ext_read) else $error("ext read differs from applied copy");
   property p_serial_hide;
      PROG_REQ.rd && SERIAL_MODE && PROG_REQ.sel == fcr_pkg::FCR_SEL_HIGH |-> ##2 PROG_RDATA[5];
   endproperty
   a_serial_hide: assert property (p_serial_hide) else $error("serial enable bit visible");
   property p_prog_freeze;
      PROG_MODE ##1 PROG_MODE ##1 PROG_MODE |=> $stable(LATCHED_FUSES);
   endproperty
   a_prog_freeze: assert property (p_prog_freeze) else $error("applied fuses moved in prog mode");
   property p_force_a;
      PWM_FORCING && quiet |-> PWM_A_SIDE_OUTPUTS == {N_PWM{~LATCHED_FUSES[20]}};
   endproperty
   a_force_a: assert property (p_force_a) else $error("forced A level wrong");
   property p_force_b;
      PWM_FORCING && quiet |-> PWM_B_SIDE_OUTPUTS == {N_PWM{~LATCHED_FUSES[19]}};
   endproperty
   a_force_b: assert property (p_force_b) else $error("forced B level wrong");
   property p_force_hold;
      PWM_FORCING && !PWM_OUTPUT_CONFIG_REG_WR |=> PWM_FORCING;
   endproperty
   a_force_hold: assert property (p_force_hold) else $error("force dropped without write");
   property p_pass;
      !PWM_FORCING |=> PWM_A_SIDE_OUTPUTS == $past(PWM_A_IN) && PWM_B_SIDE_OUTPUTS == $past(PWM_B_IN);
   endproperty
   a_pass: assert property (p_pass) else $error("PWM pass-through wrong");
   property p_clock_output_enable;
      quiet && !CFG.clock_output_enable |=> PORT_B_BIT_ZERO != $past(PORT_B_BIT_ZERO);
   endproperty
   a_clock_output_enable: assert property (p_clock_output_enable) else $error("clock not driven on port pin");
   property p_ckin;
      quiet && CFG.clock_output_enable |=> PORT_B_BIT_ZERO == $past(PORT_B_BIT_ZERO_IN);
   endproperty
   a_ckin: assert property (p_ckin) else $error("port pin not following input");
   property p_cfg_clk;
      quiet |-> CFG.clock_source_sel == LATCHED_FUSES[3:0] && CFG.startup_time_sel == LATCHED_FUSES[5:4];
   endproperty
   a_cfg_clk: assert property (p_cfg_clk) else $error("clock fields decoded wrong");
   property p_cfg_bod;
      quiet |-> CFG.brownout_level == LATCHED_FUSES[18:16] && CFG.boot_size_sel == LATCHED_FUSES[10:9];
   endproperty
   a_cfg_bod: assert property (p_cfg_bod) else $error("level or boot fields wrong");
endmodule : fcr_checker

bind fcr_top fcr_checker #(.N_PWM(N_PWM)) u_fcr_checker (.CORE_CLK(CORE_CLK), .RST(RST),
   .PROG_MODE(PROG_MODE), .SERIAL_MODE(SERIAL_MODE), .PROG_REQ(PROG_REQ),
   .PROG_RDATA(PROG_RDATA), .PWM_OUTPUT_CONFIG_REG_WR(PWM_OUTPUT_CONFIG_REG_WR),
   .PWM_A_IN(PWM_A_IN), .PWM_B_IN(PWM_B_IN), .PWM_A_SIDE_OUTPUTS(PWM_A_SIDE_OUTPUTS),
   .PWM_B_SIDE_OUTPUTS(PWM_B_SIDE_OUTPUTS), .PWM_FORCING(PWM_FORCING),
   .PORT_B_BIT_ZERO_IN(PORT_B_BIT_ZERO_IN), .PORT_B_BIT_ZERO(PORT_B_BIT_ZERO),
   .CFG(CFG), .LATCHED_FUSES(LATCHED_FUSES));

// ==== sim/fcr_prog_model.sv ====
// Programmer model: one-cycle fuse read and write pulses and the lock bit.
// Assumes the bench clock; requests change only at the falling edge.
`timescale 1ns/1ps
module fcr_prog_model (
   // Clock
   input wire logic               clk,
   // Programming side
   output fcr_pkg::fcr_prog_req_t req,
   output logic                   lock_n
);
   initial begin
      req = '0;
      lock_n = 1'b1;
   end
   task automatic access(input logic w, input logic r, input fcr_pkg::fcr_sel_t s,
                         input logic [7:0] d);
      @(negedge clk);
      req <= '{w, r, s, d};
      @(negedge clk);
      // Idle data is inverted so a stale byte never looks like a fresh one.
      req <= '{1'b0, 1'b0, s, ~d};
   endtask : access
   task automatic set_lock(input logic locked);
      @(negedge clk);
      lock_n <= ~locked;
   endtask : set_lock
endmodule : fcr_prog_model

// ==== sim/fuse_config_and_pwm_reset_state_tb.sv ====
// Self-checking bench for the fuse configuration block.
// Assumes the programmer model and the bound checker.
`timescale 1ns/1ps
module fuse_config_and_pwm_reset_state_tb;
   logic                   core_clk;
   logic                   rst;
   logic                   prog_mode;
   logic                   serial_mode;
   logic                   cfg_wr;
   logic                   pb_in;
   logic [2:0]             a_in;
   logic [2:0]             b_in;
   logic                   lock_n;
   fcr_pkg::fcr_prog_req_t req;
   logic [7:0]             rdata;
   logic [2:0]             a_out;
   logic [2:0]             b_out;
   logic                   forcing;
   logic                   pb_out;
   fcr_pkg::fcr_cfg_t      cfg;
   logic [23:0]            latched;
   int                     error_cnt;
   int                     check_count;
   int                     cyc = 0;

   fcr_prog_model prog (.clk(core_clk), .req(req), .lock_n(lock_n));
   fcr_top #(.N_PWM(3)) dut (.CORE_CLK(core_clk), .RST(rst), .PROG_MODE(prog_mode),
      .SERIAL_MODE(serial_mode), .MEMORY_LOCK_BIT_ONE_N(lock_n), .PROG_REQ(req),
      .PROG_RDATA(rdata), .PWM_OUTPUT_CONFIG_REG_WR(cfg_wr), .PWM_A_IN(a_in), .PWM_B_IN(b_in),
      .PWM_A_SIDE_OUTPUTS(a_out), .PWM_B_SIDE_OUTPUTS(b_out), .PWM_FORCING(forcing),
      .PORT_B_BIT_ZERO_IN(pb_in), .PORT_B_BIT_ZERO(pb_out), .CFG(cfg), .LATCHED_FUSES(latched));

   always #20 core_clk = ~core_clk;
   // The run needs about 110 cycles; the guard stops a hung handshake.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic rdchk(input fcr_pkg::fcr_sel_t s, input logic [7:0] exp);
      prog.access(1'b0, 1'b1, s, 8'h00);
      @(negedge core_clk);
      chk(s.name(), exp, rdata);
   endtask : rdchk
   task automatic wr(input fcr_pkg::fcr_sel_t s, input logic [7:0] d);
      prog.access(1'b1, 1'b0, s, d);
      repeat (4) @(negedge core_clk);
   endtask : wr
   task automatic t_defaults();
      rdchk(fcr_pkg::FCR_SEL_EXT, 8'hFF);
      rdchk(fcr_pkg::FCR_SEL_HIGH, 8'hD9);
      rdchk(fcr_pkg::FCR_SEL_LOW, 8'h62);
      chk("lat_ext", 8'hFF, latched[23:16]);
      chk("cksel", 8'h02, {4'h0, cfg.clock_source_sel});
      chk("sut", 8'h02, {6'h00, cfg.startup_time_sel});
      chk("boot", 8'h00, {6'h00, cfg.boot_size_sel});
   endtask : t_defaults
   task automatic t_clock_output_enable();
      logic p0;
      wr(fcr_pkg::FCR_SEL_LOW, 8'hA2);
      chk("lat_low", 8'hA2, latched[7:0]);
      p0 = pb_out;
      @(negedge core_clk);
      chk("clk_out", {7'h00, ~p0}, {7'h00, pb_out});
      pb_in = 1'b1;
      wr(fcr_pkg::FCR_SEL_LOW, 8'h62);
      chk("port_b", 8'h01, {7'h00, pb_out});
   endtask : t_clock_output_enable
   task automatic t_prog_latch();
      prog_mode = 1'b1;
      wr(fcr_pkg::FCR_SEL_HIGH, 8'hD1);
      chk("lat_hi_frozen", 8'hD9, latched[15:8]);
      chk("preserve", 8'h00, {7'h00, cfg.eeprom_preserve_on_erase});
      rdchk(fcr_pkg::FCR_SEL_HIGH, 8'hD1);
      prog_mode = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("lat_hi", 8'hD1, latched[15:8]);
   endtask : t_prog_latch
   task automatic t_serial();
      serial_mode = 1'b1;
      rdchk(fcr_pkg::FCR_SEL_HIGH, 8'hF1);
      wr(fcr_pkg::FCR_SEL_HIGH, 8'hFF);
      serial_mode = 1'b0;
      rdchk(fcr_pkg::FCR_SEL_HIGH, 8'hDF);
   endtask : t_serial
   task automatic t_lock();
      prog.set_lock(1'b1);
      wr(fcr_pkg::FCR_SEL_EXT, 8'h00);
      rdchk(fcr_pkg::FCR_SEL_EXT, 8'hFF);
      prog.set_lock(1'b0);
      wr(fcr_pkg::FCR_SEL_EXT, 8'hF9);
      chk("bod", 8'h01, {5'h00, cfg.brownout_level});
   endtask : t_lock
   task automatic t_pwm();
      a_in = 3'h5;
      b_in = 3'h2;
      repeat (2) @(negedge core_clk);
      chk("pwm_a", 8'h05, {5'h00, a_out});
      chk("pwm_b", 8'h02, {5'h00, b_out});
      chk("forcing", 8'h00, {7'h00, forcing});
      cfg_wr = 1'b1;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      a_in = 3'h2;
      repeat (2) @(negedge core_clk);
      chk("pwm_a_after", 8'h02, {5'h00, a_out});
   endtask : t_pwm
   task automatic t_force(input logic [7:0] e, input logic [2:0] ae, input logic [2:0] be);
      wr(fcr_pkg::FCR_SEL_EXT, e);
      a_in = 3'h5;
      b_in = 3'h2;
      rst = 1'b1;
      repeat (3) @(negedge core_clk);
      chk("force_rst", 8'h01, {7'h00, forcing});
      chk("force_a", {5'h00, ae}, {5'h00, a_out});
      chk("force_b", {5'h00, be}, {5'h00, b_out});
      rst = 1'b0;
      repeat (6) @(negedge core_clk);
      chk("hold_a", {5'h00, ae}, {5'h00, a_out});
      chk("hold_b", {5'h00, be}, {5'h00, b_out});
      cfg_wr = 1'b1;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      chk("free", 8'h00, {7'h00, forcing});
      chk("free_b", 8'h02, {5'h00, b_out});
   endtask : t_force
   task automatic results();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      prog_mode = 1'b0;
      serial_mode = 1'b0;
      cfg_wr = 1'b0;
      pb_in = 1'b0;
      a_in = 3'h0;
      b_in = 3'h0;
      error_cnt = 0;
      check_count = 0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      t_defaults();
      t_clock_output_enable();
      t_prog_latch();
      t_serial();
      t_lock();
      t_pwm();
      t_force(8'hCF, 3'h7, 3'h0);
      t_force(8'hD7, 3'h0, 3'h7);
      results();
   end
endmodule : fuse_config_and_pwm_reset_state_tb
